/* hw/fdo_pkg.sv */
// Constants, types and helpers of the four-channel output process image.
// Assumes one 250 MHz clock; counts are derived from it here.
package fdo_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_KHZ = 250_000;
  localparam int RESP_MS = 10;
  localparam int RESP_CYC = RESP_MS * CLK_KHZ;
  localparam int TX_US = 6500;
  localparam int TX_CYC = TX_US * (CLK_KHZ / 1000);
  localparam int WDOG_MS = 500;
  localparam int WDOG_CYC = WDOG_MS * CLK_KHZ;
  localparam int MS_CYC = CLK_KHZ;
  localparam int NCH = 4;

  // ----------------------------------------
  // Telegram layouts
  // ----------------------------------------
  localparam logic [7:0] LAY_STD = 8'h1E;
  localparam logic [7:0] LAY_2 = 8'h1F;
  localparam logic [7:0] LAY_4 = 8'h21;
  localparam logic [7:0] LAY_8 = 8'h25;
  localparam logic [2:0] PAD_STD = 3'h0;
  localparam logic [2:0] PAD_2 = 3'h1;
  localparam logic [2:0] PAD_4 = 3'h3;
  localparam logic [2:0] PAD_8 = 3'h7;

  // ----------------------------------------
  // Register map and reset values
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LFD = 8'h04;
  localparam logic [7:0] REG_SUB = 8'h08;
  localparam logic [7:0] REG_DLY = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ = 8'h14;
  localparam logic [7:0] REG_MASK = 8'h18;
  localparam logic [3:0] LFD_RST = 4'hF;
  localparam logic [5:0] SUB_RST = 6'h00;
  localparam logic [15:0] DLY_RST = 16'h0000;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam int SUB_MODE_LSB = 4;
  localparam int OFF_DLY_LSB = 8;
  localparam logic [1:0] SM_CUR = 2'h0;
  localparam logic [1:0] SM_SUB = 2'h1;
  localparam logic [1:0] SM_LAST = 2'h2;
  localparam int EV_WDOG = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_INVAL = 2;
  localparam int EV_LEN = 3;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_DATA = 3'b010,
    TX_PAD = 3'b100
  } fdo_tx_st_t;

  function automatic logic [2:0] fdo_pad(input logic [7:0] code);
    if (code == LAY_2) return PAD_2;
    else if (code == LAY_4) return PAD_4;
    else if (code == LAY_8) return PAD_8;
    else return PAD_STD;
  endfunction : fdo_pad

  function automatic logic fdo_legal(input logic [7:0] code);
    return (code == LAY_STD) || (code == LAY_2) || (code == LAY_4) || (code == LAY_8);
  endfunction : fdo_legal
endpackage : fdo_pkg

/* hw/fdo_cfg_if.sv */
// Shared channel settings from the register file to each channel.
// Assumes all users sit on sys_clk.
`timescale 1ns/1ns
interface fdo_cfg_if;
  logic [7:0] on_dly;
  logic [7:0] off_dly;
  logic [3:0] lfd_en;
  logic ms_tick;
  modport src (output on_dly, output off_dly, output lfd_en, output ms_tick);
  modport chan (input on_dly, input off_dly, input lfd_en, input ms_tick);
endinterface : fdo_cfg_if

/* hw/fdo_chan.sv */
// One output channel: on/off delay and line fault flag.
// Assumes fault_pin is asynchronous and ms_tick is a one-cycle pulse.
`timescale 1ns/1ns
module fdo_chan import fdo_pkg::*; #(
  parameter int IDX = 0
) (
  input wire logic sys_clk,
  input wire logic rst,
  fdo_cfg_if.chan cfg,
  input wire logic cmd,
  input wire logic fault_pin,
  output logic out_r,
  output logic fault_r
);
  logic [7:0] cnt_r;
  logic [7:0] dly;
  logic sync1_r;
  logic sync2_r;

  assign dly = cmd ? cfg.on_dly : cfg.off_dly;

  // ----------------------------------------
  // Delayed output
  // ----------------------------------------
  // Ms ticks are free running, so a delay may end up to 1 ms early
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (cmd == out_r) begin
      cnt_r <= 8'h00;
    end else if (cnt_r >= dly) begin
      out_r <= cmd;
      cnt_r <= 8'h00;
    end else if (cfg.ms_tick) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // ----------------------------------------
  // Line fault
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      sync1_r <= fault_pin;
      sync2_r <= sync1_r;
      fault_r <= cfg.lfd_en[IDX] & sync2_r;
    end
  end
endmodule : fdo_chan

/* hw/fdo_tx.sv */
// Input telegram sender: data byte, then zero pad bytes.
// Assumes the com unit takes a byte when tx_valid and tx_ready are high.
`timescale 1ns/1ns
module fdo_tx import fdo_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] stat,
  input wire logic [2:0] pad,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last
);
  fdo_tx_st_t st_r;
  logic [2:0] left_r;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // A start while busy is dropped; a stalled com unit skips a period
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= TX_IDLE;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      left_r <= 3'h0;
    end else begin
      case (st_r)
        TX_IDLE: begin
          if (start) begin
            st_r <= TX_DATA;
            tx_valid <= 1'b1;
            tx_data <= stat;
            tx_last <= (pad == PAD_STD);
            left_r <= pad;
          end
        end
        TX_DATA, TX_PAD: begin
          if (tx_ready) begin
            if (tx_last) begin
              st_r <= TX_IDLE;
              tx_valid <= 1'b0;
              tx_last <= 1'b0;
            end else begin
              st_r <= TX_PAD;
              tx_data <= 8'h00;
              tx_last <= (left_r == 3'h1);
              left_r <= left_r - 3'h1;
            end
          end
        end
        default: st_r <= TX_IDLE;
      endcase
    end
  end
endmodule : fdo_tx

/* hw/fdo_top.sv */
// Four-channel digital output process image with com unit link.
// Assumes the com unit runs on sys_clk; fault pins are asynchronous.
// How it works
// - A new command reaches the output pin one cycle later when no delay is set.
// - An input telegram is sent to the com unit every 6.5 ms.
// - Bytes travel in ascending order, byte 1 first, also when paired into words.
// - Input byte 1 bit 2(n-1) reports the real output state of channel n.
// - Input byte 1 bit 2(n-1)+1 reports a line fault of channel n.
// - A channel marked invalid drives its substitute value (SM_SUB), its last good value (SM_LAST) or else its received value.
// - On and off delays hold the output, and the report follows the real output.
// - Layout codes 30, 31, 33 and 37 are accepted; any other write is ignored.
// - Layouts 31, 33 and 37 append 1, 3 and 7 empty bytes each way.
// - With no good telegram for 0.5 s the outputs go to the safe state.
// - Line fault detection is enabled per channel; disabled never flags.
`timescale 1ns/1ns
module fdo_top import fdo_pkg::*; #(
  parameter int TX_PER = TX_CYC,
  parameter int WDOG_LIM = WDOG_CYC,
  parameter int MS_PER = MS_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic [3:0] fault_pin,
  output logic [3:0] out_drv,
  output logic irq
);
  localparam int TX_W = $clog2(TX_PER) + 1;
  localparam int WD_W = $clog2(WDOG_LIM) + 1;
  localparam int MS_W = $clog2(MS_PER) + 1;

  fdo_cfg_if cfg ();
  logic [7:0] lay_r;
  logic [3:0] lfd_r;
  logic [5:0] sub_r;
  logic [15:0] dly_r;
  logic [3:0] mask_r;
  logic [3:0] irq_st_r;
  logic [3:0] ev;
  logic [3:0] clr;
  logic [3:0] rx_cnt_r;
  logic [7:0] b1_r;
  logic [7:0] rx_b1;
  logic [2:0] pad;
  logic acc;
  logic len_err;
  logic [3:0] val_r;
  logic [3:0] inval_r;
  logic [3:0] good_r;
  logic [3:0] cmd_eff;
  logic [3:0] out_w;
  logic [3:0] flt_w;
  logic [3:0] flt_q_r;
  logic [7:0] stat_byte;
  logic safe_r;
  logic [WD_W-1:0] wd_cnt_r;
  logic [MS_W-1:0] ms_cnt_r;
  logic ms_tick_r;
  logic [TX_W-1:0] tx_cnt_r;
  logic tx_go_r;
  logic [1:0] sub_mode;

  assign sub_mode = sub_r[SUB_MODE_LSB +: 2];
  assign cfg.on_dly = dly_r[7:0];
  assign cfg.off_dly = dly_r[OFF_DLY_LSB +: 8];
  assign cfg.lfd_en = lfd_r;
  assign cfg.ms_tick = ms_tick_r;
  assign out_drv = out_w;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lay_r <= LAY_STD;
      lfd_r <= LFD_RST;
      sub_r <= SUB_RST;
      dly_r <= DLY_RST;
      mask_r <= MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        if (fdo_legal(reg_wdata[7:0])) lay_r <= reg_wdata[7:0];
      end else if (reg_addr == REG_LFD) begin
        lfd_r <= reg_wdata[3:0];
      end else if (reg_addr == REG_SUB) begin
        sub_r <= reg_wdata[5:0];
      end else if (reg_addr == REG_DLY) begin
        dly_r <= reg_wdata[15:0];
      end else if (reg_addr == REG_MASK) begin
        mask_r <= reg_wdata[3:0];
      end
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      if (reg_addr == REG_CTRL) reg_rdata <= {24'h0, lay_r};
      else if (reg_addr == REG_LFD) reg_rdata <= {28'h0, lfd_r};
      else if (reg_addr == REG_SUB) reg_rdata <= {26'h0, sub_r};
      else if (reg_addr == REG_DLY) reg_rdata <= {16'h0, dly_r};
      else if (reg_addr == REG_STAT) reg_rdata <= {19'h0, safe_r, inval_r, flt_w, out_w};
      else if (reg_addr == REG_IRQ) reg_rdata <= {28'h0, irq_st_r};
      else if (reg_addr == REG_MASK) reg_rdata <= {28'h0, mask_r};
      else reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign clr = (reg_wr && reg_addr == REG_IRQ) ? reg_wdata[3:0] : 4'h0;
  assign ev[EV_WDOG] = (wd_cnt_r == WD_W'(WDOG_LIM - 1)) && !acc && !safe_r;
  assign ev[EV_FAULT] = |(flt_w & ~flt_q_r);
  assign ev[EV_INVAL] = acc && |{rx_b1[7], rx_b1[5], rx_b1[3], rx_b1[1]};
  assign ev[EV_LEN] = len_err;

  // Set beats clear so no event is lost
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_st_r <= 4'h0;
      flt_q_r <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~clr) | ev;
      flt_q_r <= flt_w;
      irq <= |(irq_st_r & mask_r);
    end
  end

  // ----------------------------------------
  // Receive telegram
  // ----------------------------------------
  assign pad = fdo_pad(lay_r);
  assign rx_b1 = (rx_cnt_r == 4'h0) ? rx_data : b1_r;
  assign acc = rx_valid && rx_last && (rx_cnt_r == {1'b0, pad});
  assign len_err = rx_valid && rx_last && !acc;

  // Byte 1 comes first; pad bytes are counted, not stored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_cnt_r <= 4'h0;
      b1_r <= 8'h00;
    end else if (rx_valid) begin
      if (rx_cnt_r == 4'h0) b1_r <= rx_data;
      if (rx_last) rx_cnt_r <= 4'h0;
      else if (rx_cnt_r != 4'hF) rx_cnt_r <= rx_cnt_r + 4'h1;
    end
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wd_cnt_r <= '0;
      safe_r <= 1'b0;
    end else if (acc) begin
      wd_cnt_r <= '0;
      safe_r <= 1'b0;
    end else if (wd_cnt_r == WD_W'(WDOG_LIM - 1)) begin
      safe_r <= 1'b1;
    end else begin
      wd_cnt_r <= wd_cnt_r + WD_W'(1);
    end
  end

  // ----------------------------------------
  // Time bases
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ms_cnt_r <= '0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (ms_cnt_r == MS_W'(MS_PER - 1));
      ms_cnt_r <= (ms_cnt_r == MS_W'(MS_PER - 1)) ? '0 : ms_cnt_r + MS_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_cnt_r <= '0;
      tx_go_r <= 1'b0;
    end else begin
      tx_go_r <= (tx_cnt_r == TX_W'(TX_PER - 1));
      tx_cnt_r <= (tx_cnt_r == TX_W'(TX_PER - 1)) ? '0 : tx_cnt_r + TX_W'(1);
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic ce;
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        val_r[i] <= 1'b0;
        inval_r[i] <= 1'b0;
        good_r[i] <= 1'b0;
      end else if (acc) begin
        val_r[i] <= rx_b1[2*i];
        inval_r[i] <= rx_b1[2*i+1];
        if (!rx_b1[2*i+1]) good_r[i] <= rx_b1[2*i];
      end
    end
    always_comb begin
      if (!(inval_r[i] || safe_r)) ce = val_r[i];
      else if (sub_mode == SM_SUB) ce = sub_r[i];
      else if (sub_mode == SM_LAST) ce = good_r[i];
      else ce = val_r[i];
    end
    assign cmd_eff[i] = ce;
    assign stat_byte[2*i] = out_w[i];
    assign stat_byte[2*i+1] = flt_w[i];
    fdo_chan #(.IDX(i)) u_chan (
      .sys_clk(sys_clk),
      .rst(rst),
      .cfg(cfg.chan),
      .cmd(cmd_eff[i]),
      .fault_pin(fault_pin[i]),
      .out_r(out_w[i]),
      .fault_r(flt_w[i])
    );
  end

  fdo_tx u_tx (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(tx_go_r),
    .stat(stat_byte),
    .pad(pad),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_last(tx_last)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [TX_W-1:0] gap_r;
  logic [3:0] tx_n_r;
  logic [2:0] pad_q_r;
  // Gap starts at all ones so the first period after reset also spans TX_PER
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gap_r <= '1;
      tx_n_r <= 4'h0;
      pad_q_r <= PAD_STD;
    end else begin
      gap_r <= tx_go_r ? '0 : gap_r + TX_W'(1);
      if (tx_valid && tx_ready) tx_n_r <= tx_last ? 4'h0 : tx_n_r + 4'h1;
      // Pad count is fixed when a telegram starts; a layout write mid-telegram waits
      if (tx_go_r && !tx_valid) pad_q_r <= pad;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_resp;
    (cmd_eff[0] != out_w[0]) && (dly_r == 16'h0) |=> out_drv[0] == $past(cmd_eff[0]);
  endproperty
  a_resp: assert property (p_resp) else $error("output missed response");
  property p_period;
    tx_go_r && $past(gap_r) != '0 |-> gap_r == TX_W'(TX_PER - 1);
  endproperty
  a_period: assert property (p_period) else $error("telegram period wrong");
  property p_first;
    $rose(tx_valid) |-> tx_data == $past(stat_byte);
  endproperty
  a_first: assert property (p_first) else $error("first byte not status");
  property p_stat;
    $rose(tx_valid) |-> tx_data[0] == $past(out_w[0]) && tx_data[7] == $past(flt_w[3]);
  endproperty
  a_stat: assert property (p_stat) else $error("status bits misplaced");
  property p_nofault;
    ##1 (flt_w & ~$past(lfd_r)) == 4'h0;
  endproperty
  a_nofault: assert property (p_nofault) else $error("fault while disabled");
  property p_subst;
    acc && rx_b1[1] && sub_mode == SM_SUB && dly_r == 16'h0 && !safe_r
      |-> ##2 out_drv[0] == $past(sub_r[0], 2);
  endproperty
  a_subst: assert property (p_subst) else $error("substitute not driven");
  property p_ondly;
    cmd_eff[0] && !out_w[0] && dly_r[7:0] != 8'h00 && $changed(cmd_eff[0]) |=> !out_w[0];
  endproperty
  a_ondly: assert property (p_ondly) else $error("on delay skipped");
  property p_layout;
    reg_wr && reg_addr == REG_CTRL && !fdo_legal(reg_wdata[7:0]) |=> $stable(lay_r);
  endproperty
  a_layout: assert property (p_layout) else $error("illegal layout taken");
  property p_pad;
    tx_valid && tx_ready && tx_last |-> tx_n_r == {1'b0, pad_q_r};
  endproperty
  a_pad: assert property (p_pad) else $error("wrong pad count");
  property p_wdog;
    wd_cnt_r == WD_W'(WDOG_LIM - 1) && !acc |=> safe_r;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog missed");

  c_pad: cover property (tx_valid && tx_ready && tx_last && pad == PAD_8);
  c_safe: cover property ($rose(safe_r));
  c_inval: cover property (ev[EV_INVAL]);
  c_len: cover property (len_err);
endmodule : fdo_top

/* verification/fdo_com_model.sv */
// Com unit model: sends output telegrams, takes input telegrams.
// Assumes it shares sys_clk with the block and obeys the bench's send pulse.
`timescale 1ns/1ns
module fdo_com_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic send,
  input wire logic [7:0] send_b1,
  input wire logic [3:0] send_len,
  input wire logic slow,
  output logic busy,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic tel_done,
  output logic [12:0] tel_info
);
  logic [3:0] left_r;
  logic [3:0] cnt_r;
  logic [7:0] stat_r;
  logic bad_r;
  logic pad_bad;
  assign busy = (left_r != 4'h0) || rx_valid;
  assign pad_bad = (cnt_r != 4'h0) && (tx_data != 8'h00);
  // ----------------------------------------
  // Output telegram
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      left_r <= 4'h0;
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= 8'h00;
    end else if (left_r != 4'h0) begin
      rx_valid <= 1'b1;
      rx_data <= (left_r == send_len) ? send_b1 : ~send_b1;
      rx_last <= (left_r == 4'h1);
      left_r <= left_r - 4'h1;
    end else begin
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~rx_data; // Idle line never repeats stale data
      if (send) begin
        left_r <= send_len;
      end
    end
  end
  // ----------------------------------------
  // Input telegram
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      tx_ready <= 1'b0;
      cnt_r <= 4'h0;
      stat_r <= 8'h00;
      bad_r <= 1'b0;
      tel_done <= 1'b0;
      tel_info <= 13'h0;
    end else begin
      tx_ready <= !slow || !tx_ready; // Slow mode stalls every other cycle
      tel_done <= 1'b0;
      if (tx_valid && tx_ready) begin
        cnt_r <= cnt_r + 4'h1;
        bad_r <= bad_r || pad_bad;
        if (cnt_r == 4'h0) begin
          stat_r <= tx_data;
        end
        if (tx_last) begin
          tel_done <= 1'b1;
          tel_info <= {bad_r || pad_bad, cnt_r + 4'h1, (cnt_r == 4'h0) ? tx_data : stat_r};
          cnt_r <= 4'h0;
          bad_r <= 1'b0;
        end
      end
    end
  end
endmodule : fdo_com_model

/* verification/fdo_bench.sv */
// Self-checking bench of the four-channel output process image.
// Assumes fdo_top, the com unit model and short timing parameters.
`timescale 1ns/1ns
module four_channel_output_process_image_bench import fdo_pkg::*;;
  typedef struct {
    int kind;
    logic [31:0] exp;
    logic [31:0] msk;
  } fdo_note_t;
  localparam int MS = 10;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic rx_valid, rx_last, tx_valid, tx_last, tx_ready, irq, busy, tel_done;
  logic [7:0] rx_data, tx_data, b1;
  logic [3:0] out_drv;
  logic [3:0] fault_pin = 4'h0;
  logic send = 1'b0, slow = 1'b0, samp = 1'b0, rd_d = 1'b0;
  logic [7:0] send_b1 = 8'h00;
  logic [3:0] send_len = 4'h1;
  logic [12:0] tel_info;
  integer seed = 32'h1DB1;
  int err_count = 0;
  int num_checks = 0;
  fdo_note_t notes[$];
  logic [7:0] codes [4] = '{LAY_STD, LAY_2, LAY_4, LAY_8};
  logic [2:0] pads [4] = '{PAD_STD, PAD_2, PAD_4, PAD_8};

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  fdo_top #(.TX_PER(200), .WDOG_LIM(500), .MS_PER(MS)) uut (.sys_clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_valid, .rx_data, .rx_last, .tx_valid,
    .tx_data, .tx_last, .tx_ready, .fault_pin, .out_drv, .irq);
  fdo_com_model com (.sys_clk, .rst, .send, .send_b1, .send_len, .slow, .busy, .rx_valid,
    .rx_data, .rx_last, .tx_valid, .tx_data, .tx_last, .tx_ready, .tel_done, .tel_info);

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic take(input int k, input string nm, input logic [31:0] g);
    fdo_note_t n;
    if (notes.size() != 0 && notes[0].kind == k) begin
      n = notes.pop_front();
      chk(nm, n.exp, g & n.msk);
    end
  endtask : take

  // Periodic telegrams with no note pending are simply absorbed
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (rd_d) take(0, "reg_rdata", reg_rdata);
    if (samp) take(1, "irq_out", {27'h0, irq, out_drv});
    if (tel_done) take(2, "telegram", {19'h0, tel_info});
  end

  task automatic note(input int k, input logic [31:0] e, input logic [31:0] m);
    fdo_note_t n;
    n.kind = k;
    n.exp = e;
    n.msk = m;
    notes.push_back(n);
  endtask : note

  task automatic print_verdict;
    if (notes.size() != 0) begin
      err_count++;
      $display("[ERR] pending_notes expected 0 seen %0d", notes.size());
    end
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    note(0, e, m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask : rd

  task automatic look(input logic [4:0] e);
    note(1, {27'h0, e}, 32'h1F);
    samp <= 1'b1;
    @(posedge sys_clk);
    samp <= 1'b0;
    @(posedge sys_clk);
  endtask : look

  task automatic tx(input logic [7:0] b, input logic [3:0] n);
    send_b1 <= b;
    send_len <= n;
    send <= 1'b1;
    @(posedge sys_clk);
    send <= 1'b0;
    @(posedge sys_clk);
    while (busy) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask : tx

  // First telegram may carry a status sampled before the change
  task automatic tel(input logic [7:0] s, input logic [3:0] n);
    @(posedge sys_clk iff tel_done);
    @(posedge sys_clk);
    note(2, {19'h0, 1'b0, n, s}, 32'h1FFF);
    @(posedge sys_clk iff tel_done);
    @(posedge sys_clk);
  endtask : tel

  function automatic logic [3:0] od(input logic [7:0] b);
    return {b[6], b[4], b[2], b[0]};
  endfunction : od

  function automatic logic [7:0] st(input logic [3:0] o, input logic [3:0] f);
    for (int i = 0; i < 4; i++) begin
      st[2*i] = o[i];
      st[2*i+1] = f[i];
    end
  endfunction : st

  initial begin
    repeat (40000) @(posedge sys_clk);
    err_count++;
    print_verdict();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(REG_CTRL, {24'h0, LAY_STD}, ALL);
    rd(REG_LFD, {28'h0, LFD_RST}, ALL);
    rd(REG_SUB, 32'h0, ALL);
    rd(REG_DLY, 32'h0, ALL);
    rd(REG_MASK, 32'h0, ALL);
    wr(8'h1C, ALL);
    rd(8'h1C, 32'h0, ALL);
    wr(REG_CTRL, 32'h20);
    rd(REG_CTRL, {24'h0, LAY_STD}, ALL);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      b1 = 8'($random(seed)) & 8'h55;
      slow <= b1[2];
      wr(REG_CTRL, {24'h0, codes[i]});
      rd(REG_CTRL, {24'h0, codes[i]}, ALL);
      tx(b1, {1'b0, pads[i]} + 4'h1);
      look({1'b0, od(b1)});
      tel(st(od(b1), 4'h0), {1'b0, pads[i]} + 4'h1);
    end
    tx(~b1, 4'h3);
    look({1'b0, od(b1)});
    rd(REG_IRQ, 32'h8, 32'h8);
    wr(REG_IRQ, 32'hF);
    rd(REG_IRQ, 32'h0, 32'h8);
    wr(REG_CTRL, {24'h0, LAY_STD});
    slow <= 1'b0;
    $display("test layouts done");
    wr(REG_SUB, 32'h1A);
    tx(8'hFF, 4'h1);
    look(5'h0A);
    rd(REG_STAT, 32'hF00, 32'hF00);
    wr(REG_MASK, 32'h4);
    look(5'h1A);
    wr(REG_IRQ, 32'h4);
    look(5'h0A);
    wr(REG_MASK, 32'h0);
    wr(REG_SUB, 32'h20);
    look({1'b0, od(b1)});
    wr(REG_SUB, 32'h0);
    $display("test invalid done");
    fault_pin <= 4'h5;
    tx(8'h00, 4'h1);
    rd(REG_STAT, 32'h50, 32'hFF);
    tel(8'h22, 4'h1);
    wr(REG_LFD, 32'h0);
    rd(REG_STAT, 32'h0, 32'hF0);
    tel(8'h00, 4'h1);
    fault_pin <= 4'h0;
    wr(REG_LFD, 32'hF);
    $display("test fault done");
    wr(REG_DLY, 32'h4);
    tx(8'h55, 4'h1);
    look(5'h00);
    rd(REG_STAT, 32'h0, 32'hF);
    repeat (6 * MS) @(posedge sys_clk);
    look(5'h0F);
    rd(REG_STAT, 32'hF, 32'hF);
    wr(REG_DLY, 32'h0);
    $display("test delay done");
    wr(REG_SUB, 32'h16);
    tx(8'h00, 4'h1);
    look(5'h00);
    repeat (600) @(posedge sys_clk);
    look(5'h06);
    rd(REG_STAT, 32'h1000, 32'h1000);
    rd(REG_IRQ, 32'h1, 32'h1);
    $display("test watchdog done");
    repeat (2) @(posedge sys_clk);
    print_verdict();
  end
endmodule : four_channel_output_process_image_bench
